// file: cms_consts.svh
`ifndef CMS_CONSTS_SVH
`define CMS_CONSTS_SVH

// Core clock and timing figures.
`define CMS_CORE_HZ        25000000
`define CMS_DB_SHORT_MS    150
`define CMS_DB_LONG_MS     1300
`define CMS_AUTO_DB_MS     1
`define CMS_EXIT_SHORT_MS  20
`define CMS_EXIT_LONG_MS   200
`define CMS_AUTO_LIMIT_H   12
`define CMS_CONFIG_RESISTOR_PIN_SETTLE_US 40
`define CMS_MIN_LS_NS      200

// Register command codes.
`define CMS_FAST_OFS 8'h14
`define CMS_VMAX_OFS 8'h15
`define CMS_CFG1_OFS 8'h3c
`define CMS_CFG2_OFS 8'h3d
`define CMS_CFG3_OFS 8'h4c
`define CMS_CFG_RST  16'h0000

// Field positions.
`define CMS_CFG1_MON_OFF   5
`define CMS_CFG1_FSW_LSB   8
`define CMS_CFG1_LEARN     12
`define CMS_CFG1_VMIN_EXIT 13
`define CMS_CFG2_CMP_OFF   3
`define CMS_CFG2_DB_LONG   11
`define CMS_CFG3_AUTO_EN   7
`define CMS_CFG3_BFET_OFF  10
`define CMS_CFG3_EXIT_LONG 13

// Currents in mA, one current command step, voltages in mV.
`define CMS_LSB_MA         4
`define CMS_ILIM_HI_MA     1500
`define CMS_ILIM_LO_MA     476
`define CMS_AUTO_CHG_MA    2000
`define CMS_AUTO_MARGIN_MV 200
`define CMS_FSW_733K       2'h0
`define CMS_FSW_1M         2'h1
`define CMS_CONFIG_RESISTOR_PIN_CODES     18

`endif

// file: cms_pkg.sv
package cms_pkg;

	typedef enum logic [2:0] {PH_OFF, PH_DEBOUNCE, PH_CONFIG_RESISTOR_PIN, PH_SOFTON, PH_READY} cms_phase_t;

	typedef struct packed {
		logic vdd_active;
		logic vdd_good;
		logic adp_det;
		logic input_sense_node_ok;
		logic adapter_sense_input_ok;
		logic asg_full;
		logic bat_present;
		logic vbat_below_auto;
		logic vbat_at_max;
		logic chg_low_cv;
		logic vbat_below_min;
		logic bat_gone;
		logic zce_en;
		logic ls_req;
	} cms_sense_t;

	typedef struct packed {
		logic [2:0] cells;
		logic       fsw_1m;
		logic       auto_en;
		logic       ilim_hi;
	} cms_config_resistor_pin_t;

	typedef struct packed {
		logic        asg;
		logic        adapter_good_output_oe;
		logic        bfet;
		logic        sw_en;
		logic        config_resistor_pin_src;
		logic        alert_oe;
		logic        timeout_susp;
		logic        low_power;
		logic        ship;
		logic        mon_off;
		logic        cmp_off;
		logic        ls_on;
		logic [1:0]  fsw;
		logic [15:0] ilim;
		logic [15:0] chg;
		logic [15:0] upper;
		logic [15:0] lower;
		logic [15:0] auto_thr;
	} cms_drive_t;

	typedef struct packed {
		logic [36:0] sh;
	} cms_link_t;

endpackage

// file: cms_sequencer.sv
// What this block does
// - Logic idle and bus ignored until bias active.
// - Adapter debounce 150ms first, then config-selected.
// - Short on input bus keeps adapter switch off.
// - Release adapter-good when bias, sense, switch good.
// - Drive adapter-good low without adapter.
// - Source current, sample resistor before switch on.
// - Battery only selects low power state.
// - Decode resistor into eighteen default codes.
// - Cell count sets regulation voltage defaults.
// - Host write to word one sets frequency.
// - Insertion reloads input ceiling, reading once.
// - Current command step is four milliamps.
// - Auto enable from code or bit; writes cancel.
// - Enter auto after 1ms low with FET on.
// - Auto charges 2A, pulls alert, suspends timeout.
// - Leave auto after low CV current time.
// - Re-enter auto when battery falls again.
// - Twelve hour auto limit stops charging.
// - Ship mode from battery only via bits.
// - Zero cross emulation keeps minimum low-side on-time.
// - Learn: battery FET on, switch on, no switching.
// - Learn exits by command, low battery, battery removal.
`timescale 1ns/100ps
`default_nettype none
`include "cms_consts.svh"
module cms_sequencer #(
	parameter logic [6:0]        DEV_ADDR       = 7'h2a,
	parameter int unsigned       DB_SHORT_CYC   = 32'(64'(`CMS_DB_SHORT_MS) * `CMS_CORE_HZ / 1000),
	parameter int unsigned       DB_LONG_CYC    = 32'(64'(`CMS_DB_LONG_MS) * `CMS_CORE_HZ / 1000),
	parameter int unsigned       AUTO_DB_CYC    = 32'(64'(`CMS_AUTO_DB_MS) * `CMS_CORE_HZ / 1000),
	parameter int unsigned       EXIT_SHORT_CYC = 32'(64'(`CMS_EXIT_SHORT_MS) * `CMS_CORE_HZ / 1000),
	parameter int unsigned       EXIT_LONG_CYC  = 32'(64'(`CMS_EXIT_LONG_MS) * `CMS_CORE_HZ / 1000),
	parameter longint unsigned   AUTO_LIMIT_CYC = 64'(`CMS_AUTO_LIMIT_H) * 3600 * `CMS_CORE_HZ,
	parameter int unsigned       UPPER_MV_CELL  = 4200,
	parameter int unsigned       LOWER_MV_CELL  = 3000
) (
	input  wire logic               core_clk_i,
	input  wire logic               rst_i,
	input  wire logic               smb_clk_i,
	input  wire logic               smb_data_i,
	input  wire cms_pkg::cms_sense_t sense_i,
	input  wire logic [4:0]         config_resistor_pin_bin_i,
	output var  cms_pkg::cms_drive_t drive_o
);
	import cms_pkg::*;

	localparam int unsigned CONFIG_RESISTOR_PIN_SETTLE_CYC = (`CMS_CONFIG_RESISTOR_PIN_SETTLE_US * (`CMS_CORE_HZ / 1000000));
	localparam int unsigned MIN_LS_CYC      = (`CMS_MIN_LS_NS * (`CMS_CORE_HZ / 1000000) + 999) / 1000;
	localparam logic [15:0] ILIM_HI  = 16'(`CMS_ILIM_HI_MA / `CMS_LSB_MA);
	localparam logic [15:0] ILIM_LO  = 16'(`CMS_ILIM_LO_MA / `CMS_LSB_MA);
	localparam logic [15:0] AUTO_CHG = 16'(`CMS_AUTO_CHG_MA / `CMS_LSB_MA);
	// Each entry is {frequency 1M, autonomous enable, 1.5A ceiling}.
	localparam logic [2:0] CONFIG_RESISTOR_PIN_TAB [`CMS_CONFIG_RESISTOR_PIN_CODES] = '{
		3'h3, 3'h2, 3'h4, 3'h5, 3'h1, 3'h0, 3'h0, 3'h1, 3'h5,
		3'h4, 3'h2, 3'h3, 3'h3, 3'h2, 3'h4, 3'h5, 3'h1, 3'h0};

	if (DB_SHORT_CYC == 0 || AUTO_DB_CYC == 0 || EXIT_SHORT_CYC == 0 || DB_LONG_CYC == 0 ||
	    EXIT_LONG_CYC == 0 || AUTO_LIMIT_CYC == 0 || AUTO_LIMIT_CYC >= 64'h200_0000_0000) begin : g_chk
		$error("cms_sequencer: interval parameters out of range");
	end

	typedef struct packed {
		cms_sense_t  s1;
		cms_sense_t  s2;
		logic [4:0]  pb1;
		logic [4:0]  pb2;
		logic [1:0]  l1;
		logic [1:0]  l2;
		logic [1:0]  l3;
		logic        bg3;
		cms_phase_t  ph;
		logic [31:0] cnt;
		logic        first_done;
		logic        config_resistor_pin_read;
		cms_config_resistor_pin_t   config_resistor_pin;
		logic [15:0] cfg1;
		logic [15:0] cfg2;
		logic [15:0] cfg3;
		logic [15:0] fast;
		logic        fsw_host;
		logic        auto_host;
		logic        vmax_host;
		logic        auto_en;
		logic        auto;
		logic        chg_stop;
		logic [31:0] a_cnt;
		logic [40:0] lim_cnt;
		logic        learn;
		logic [7:0]  ls_cnt;
		cms_drive_t  drv;
	} cms_core_t;

	cms_core_t   q;
	cms_core_t   n;
	cms_link_t   ql;
	cms_link_t   nl;
	logic        stop;
	logic        wr;
	logic [7:0]  cmd;
	logic [15:0] wdat;

	function automatic cms_config_resistor_pin_t config_resistor_pin_decode(input logic [4:0] bin);
		cms_config_resistor_pin_t   p;
		logic [4:0]  idx;
		idx = (bin < 5'(`CMS_CONFIG_RESISTOR_PIN_CODES)) ? bin : 5'(`CMS_CONFIG_RESISTOR_PIN_CODES - 1);
		p.cells = (idx < 5'd6) ? 3'h2 : ((idx < 5'd12) ? 3'h3 : 3'h4);
		{p.fsw_1m, p.auto_en, p.ilim_hi} = CONFIG_RESISTOR_PIN_TAB[idx];
		return p;
	endfunction

	// Link side: every SCL rise shifts one data bit; the last 37 bits are one write-word frame and the stop.
	always_comb begin
		nl    = ql;
		nl.sh = {ql.sh[35:0], smb_data_i};
	end

	always_ff @(posedge smb_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ql <= '0;
		end else begin
			ql <= nl;
		end
	end

	// A stop condition leaves SCL high, so the shift register is frozen while the core copies it.
	// The stop's own SCL rise shifts in one extra bit, so the frame sits one place above bit 0.
	assign stop = q.l2[1] && q.l3[1] && q.l2[0] && !q.l3[0];
	assign wr   = stop && ql.sh[36:29] == {DEV_ADDR, 1'b0} && q.s2.vdd_active;
	assign cmd  = ql.sh[27:20];
	assign wdat = {ql.sh[9:2], ql.sh[18:11]};

	always_comb begin
		n     = q;
		n.s1  = sense_i;
		n.s2  = q.s1;
		n.pb1 = config_resistor_pin_bin_i;
		n.pb2 = q.pb1;
		n.l1  = {smb_clk_i, smb_data_i};
		n.l2  = q.l1;
		n.l3  = q.l2;
		n.bg3 = q.s2.bat_gone;

		if (wr) begin
			case (cmd)
				`CMS_CFG1_OFS: begin
					n.cfg1     = wdat;
					n.fsw_host = 1'b1;
					if (wdat[`CMS_CFG1_LEARN] && !q.cfg1[`CMS_CFG1_LEARN]) begin
						n.learn = 1'b1;
					end
				end
				`CMS_CFG2_OFS: n.cfg2 = wdat;
				`CMS_CFG3_OFS: begin
					n.cfg3      = wdat;
					n.auto_en   = wdat[`CMS_CFG3_AUTO_EN];
					n.auto_host = 1'b1;
				end
				`CMS_FAST_OFS: begin
					n.fast      = wdat;
					n.chg_stop  = 1'b0;
					n.auto_en   = 1'b0;
					n.auto_host = 1'b1;
				end
				`CMS_VMAX_OFS: begin
					n.drv.upper = wdat;
					n.vmax_host = 1'b1;
					n.auto_en   = 1'b0;
					n.auto_host = 1'b1;
				end
				default: begin
				end
			endcase
		end

		if ((wr && cmd == `CMS_CFG1_OFS && !wdat[`CMS_CFG1_LEARN]) ||
		    (q.cfg1[`CMS_CFG1_VMIN_EXIT] && q.s2.vbat_below_min) ||
		    (q.s2.bat_gone && !q.bg3)) begin
			n.learn = 1'b0;
		end

		unique case (q.ph)
			PH_OFF: begin
				n.cnt = '0;
				if (q.s2.adp_det) begin
					n.ph = PH_DEBOUNCE;
				end
			end
			PH_DEBOUNCE: begin
				if (!q.s2.adp_det) begin
					n.ph  = PH_OFF;
					n.cnt = '0;
				end else if (!(q.s2.input_sense_node_ok && q.s2.adapter_sense_input_ok)) begin
					n.cnt = '0;
				end else if (q.cnt == ((q.first_done && q.cfg2[`CMS_CFG2_DB_LONG]) ?
				                       DB_LONG_CYC - 1 : DB_SHORT_CYC - 1)) begin
					n.cnt = '0;
					n.ph  = PH_CONFIG_RESISTOR_PIN;
				end else begin
					n.cnt = q.cnt + 32'h1;
				end
			end
			PH_CONFIG_RESISTOR_PIN: begin
				if (!q.s2.adp_det) begin
					n.ph = PH_OFF;
				end else if (q.config_resistor_pin_read || q.cnt == CONFIG_RESISTOR_PIN_SETTLE_CYC - 1) begin
					if (!q.config_resistor_pin_read) begin
						n.config_resistor_pin = config_resistor_pin_decode(q.pb2);
					end
					n.config_resistor_pin_read = 1'b1;
					n.drv.ilim  = n.config_resistor_pin.ilim_hi ? ILIM_HI : ILIM_LO;
					if (!q.vmax_host) begin
						n.drv.upper = 16'(n.config_resistor_pin.cells * UPPER_MV_CELL);
					end
					n.drv.lower = 16'(n.config_resistor_pin.cells * LOWER_MV_CELL);
					if (!q.auto_host) begin
						n.auto_en = n.config_resistor_pin.auto_en;
					end
					n.ph = PH_SOFTON;
				end else begin
					n.cnt = q.cnt + 32'h1;
				end
			end
			PH_SOFTON: begin
				n.first_done = 1'b1;
				if (!q.s2.adp_det) begin
					n.ph = PH_OFF;
				end else if (q.s2.vdd_good && q.s2.adapter_sense_input_ok && q.s2.asg_full) begin
					n.ph = PH_READY;
				end
			end
			PH_READY: begin
				if (!q.s2.adp_det || !q.s2.adapter_sense_input_ok) begin
					n.ph = PH_OFF;
				end
			end
			default: n.ph = PH_OFF;
		endcase

		if (!q.auto) begin
			if (q.auto_en && q.drv.bfet && q.s2.vbat_below_auto) begin
				if (q.a_cnt == AUTO_DB_CYC - 1) begin
					n.auto     = 1'b1;
					n.chg_stop = 1'b0;
					n.a_cnt    = '0;
					n.lim_cnt  = '0;
				end else begin
					n.a_cnt = q.a_cnt + 32'h1;
				end
			end else begin
				n.a_cnt = '0;
			end
		end else begin
			n.lim_cnt = q.s2.vbat_at_max ? '0 : q.lim_cnt + 41'h1;
			if (!(q.auto_en && q.drv.bfet)) begin
				n.auto = 1'b0;
			end else if (q.lim_cnt == 41'(AUTO_LIMIT_CYC - 1)) begin
				n.auto     = 1'b0;
				n.chg_stop = 1'b1;
			end
			if (!q.s2.chg_low_cv) begin
				n.a_cnt = '0;
			end else if (q.a_cnt == (q.cfg3[`CMS_CFG3_EXIT_LONG] ? EXIT_LONG_CYC - 1 : EXIT_SHORT_CYC - 1)) begin
				n.auto  = 1'b0;
				n.a_cnt = '0;
			end else begin
				n.a_cnt = q.a_cnt + 32'h1;
			end
		end

		// Period stretch: a short low-side request is held to the minimum on-time.
		n.ls_cnt     = q.drv.ls_on ? ((q.ls_cnt == 8'(MIN_LS_CYC)) ? q.ls_cnt : q.ls_cnt + 8'h1) : 8'h0;
		n.drv.ls_on  = q.s2.ls_req || (q.s2.zce_en && q.drv.ls_on && q.ls_cnt < 8'(MIN_LS_CYC - 1));

		if (!q.s2.vdd_active) begin
			n.ph         = PH_OFF;
			n.cnt        = '0;
			n.first_done = 1'b0;
			n.config_resistor_pin_read  = 1'b0;
			n.cfg1       = `CMS_CFG_RST;
			n.cfg2       = `CMS_CFG_RST;
			n.cfg3       = `CMS_CFG_RST;
			n.fsw_host   = 1'b0;
			n.auto_host  = 1'b0;
			n.vmax_host  = 1'b0;
			n.auto_en    = 1'b0;
			n.auto       = 1'b0;
			n.a_cnt      = '0;
			n.learn      = 1'b0;
		end

		n.drv.asg          = n.ph == PH_SOFTON || n.ph == PH_READY || n.learn;
		n.drv.adapter_good_output_oe      = !(q.ph == PH_READY && q.s2.adp_det && q.s2.vdd_good &&
		                       q.s2.adapter_sense_input_ok && q.s2.asg_full);
		n.drv.sw_en        = q.ph == PH_READY && !q.drv.adapter_good_output_oe && !n.learn;
		n.drv.bfet         = n.learn || (q.s2.bat_present && !n.cfg3[`CMS_CFG3_BFET_OFF]);
		n.drv.config_resistor_pin_src     = n.ph == PH_CONFIG_RESISTOR_PIN && !n.config_resistor_pin_read;
		n.drv.alert_oe     = n.auto;
		n.drv.timeout_susp = n.auto;
		n.drv.low_power    = n.ph == PH_OFF && q.s2.bat_present && !q.s2.adp_det;
		n.drv.ship         = n.drv.low_power && n.cfg1[`CMS_CFG1_MON_OFF] &&
		                     n.cfg2[`CMS_CFG2_CMP_OFF] && n.cfg3[`CMS_CFG3_BFET_OFF];
		n.drv.mon_off      = n.cfg1[`CMS_CFG1_MON_OFF];
		n.drv.cmp_off      = n.cfg2[`CMS_CFG2_CMP_OFF];
		n.drv.fsw          = n.fsw_host ? n.cfg1[`CMS_CFG1_FSW_LSB +: 2] :
		                     (n.config_resistor_pin.fsw_1m ? `CMS_FSW_1M : `CMS_FSW_733K);
		n.drv.chg          = n.auto ? AUTO_CHG : (n.chg_stop ? 16'h0000 : n.fast);
		n.drv.auto_thr     = n.drv.upper - 16'(n.config_resistor_pin.cells * `CMS_AUTO_MARGIN_MV);
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			q             <= '0;
			q.drv.adapter_good_output_oe <= 1'b1;
		end else begin
			q <= n;
		end
	end

	assign drive_o = q.drv;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	sequence s_gone;
		q.learn && $rose(q.s2.bat_gone);
	endsequence
	sequence s_enter;
		!q.auto && q.auto_en && q.drv.bfet && q.s2.vbat_below_auto;
	endsequence

	a_adapter_good_output_release: assert property (!q.drv.adapter_good_output_oe |->
		$past(q.s2.vdd_good && q.s2.adapter_sense_input_ok && q.s2.asg_full)) else $error("adapter-good released early");
	a_adapter_good_output_noadp: assert property (!$past(q.s2.adp_det) |-> q.drv.adapter_good_output_oe)
		else $error("adapter-good not driven low");
	a_short_hold: assert property (q.ph == PH_DEBOUNCE && !(q.s2.input_sense_node_ok && q.s2.adapter_sense_input_ok) |=>
		q.ph != PH_CONFIG_RESISTOR_PIN && q.cnt == 32'h0) else $error("short did not hold debounce");
	a_config_resistor_pin_before: assert property ($rose(q.drv.asg) && !q.learn |-> q.config_resistor_pin_read)
		else $error("switch on before resistor read");
	a_learn_drive: assert property (q.learn |-> q.drv.asg && q.drv.bfet && !q.drv.sw_en)
		else $error("learn drive wrong");
	a_learn_exit: assert property (s_gone |=> !q.learn)
		else $error("learn not left on battery removal");
	a_auto_enter: assert property ($rose(q.auto) |-> $past(q.a_cnt) == AUTO_DB_CYC - 1)
		else $error("auto entered without full debounce");
	a_auto_debounce: assert property (s_enter ##0 (q.a_cnt == AUTO_DB_CYC - 1) |=> q.auto)
		else $error("auto not entered after debounce");
	a_auto_signs: assert property (q.auto |-> q.drv.alert_oe && q.drv.timeout_susp &&
		q.drv.chg == AUTO_CHG) else $error("auto indications wrong");
	a_auto_cancel: assert property (wr && (cmd == `CMS_FAST_OFS || cmd == `CMS_VMAX_OFS) |=>
		!q.auto_en ##1 !q.auto) else $error("host write did not cancel auto");
	a_fsw_host: assert property (q.fsw_host |-> q.drv.fsw == q.cfg1[`CMS_CFG1_FSW_LSB +: 2])
		else $error("frequency selection not applied");
	a_ship_only: assert property (q.drv.ship |-> q.drv.low_power && $past(q.s2.bat_present))
		else $error("ship outside battery only");
endmodule
`default_nettype wire

// file: cms_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module cms_host_model (
	output logic scl_o,
	output logic sda_o
);
	// The clock idles high between frames; released data reads high through the bus pull-up.
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	task automatic send_bit(input logic b);
		scl_o = 1'b0;
		#10;
		sda_o = b;
		#30;
		scl_o = 1'b1;
		#40;
	endtask

	// Acknowledge slots are left released, since the device never answers on the data line.
	task automatic write_word(input logic [6:0] addr, input logic [7:0] cmd, input logic [15:0] data);
		logic [35:0] fr;
		fr = {addr, 1'b0, 1'b1, cmd, 1'b1, data[7:0], 1'b1, data[15:8], 1'b1};
		#7;
		sda_o = 1'b0;
		#40;
		for (int i = 35; i >= 0; i--) begin
			send_bit(fr[i]);
		end
		scl_o = 1'b0;
		#10;
		sda_o = 1'b0;
		#30;
		scl_o = 1'b1;
		#40;
		sda_o = 1'b1;
		#400;
	endtask
endmodule
`default_nettype wire

// file: test_cms_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module test_cms_sequencer;
	import cms_pkg::*;
	localparam int DB_S = 200;
	localparam int DB_L = 400;
	localparam int A_DB = 20;
	localparam int EX_S = 30;
	localparam int LIM  = 500;
	localparam int SET  = 1000;
	logic       core_clk;
	logic       rst;
	logic       scl;
	logic       sda;
	cms_sense_t sense;
	logic [4:0] config_resistor_pin_bin;
	cms_drive_t dr;
	int         fail_count;
	int         n_compared;

	cms_host_model host (.scl_o(scl), .sda_o(sda));
	cms_sequencer #(.DB_SHORT_CYC(DB_S), .DB_LONG_CYC(DB_L), .AUTO_DB_CYC(A_DB), .EXIT_SHORT_CYC(EX_S),
		.EXIT_LONG_CYC(60), .AUTO_LIMIT_CYC(LIM)) uut (
		.core_clk_i(core_clk), .rst_i(rst), .smb_clk_i(scl), .smb_data_i(sda),
		.sense_i(sense), .config_resistor_pin_bin_i(config_resistor_pin_bin), .drive_o(dr));

	always #20 core_clk = ~core_clk;

	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
		host.write_word(7'h2a, cmd, data);
		tick(8);
	endtask

	task automatic print_verdict;
		if (fail_count == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		#2000000;
		fail_count++;
		print_verdict();
	end

	initial begin
		core_clk = 1'b0;
		rst = 1'b1;
		sense = '0;
		config_resistor_pin_bin = 5'h00;
		fail_count = 0;
		n_compared = 0;
		tick(6);
		chk("adapter_good_output_oe", 16'h1, 16'(dr.adapter_good_output_oe));
		chk("asg", 16'h0, 16'(dr.asg));
		rst = 1'b0;
		tick(4);
		wr(8'h3c, 16'h0100);
		chk("fsw", 16'h0, 16'(dr.fsw));
		sense.vdd_active = 1'b1;
		sense.vdd_good = 1'b1;
		sense.bat_present = 1'b1;
		sense.adp_det = 1'b1;
		tick(DB_S + 100);
		chk("asg", 16'h0, 16'(dr.asg));
		chk("config_resistor_pin_src", 16'h0, 16'(dr.config_resistor_pin_src));
		sense.input_sense_node_ok = 1'b1;
		sense.adapter_sense_input_ok = 1'b1;
		tick(DB_S - 4);
		chk("config_resistor_pin_src", 16'h0, 16'(dr.config_resistor_pin_src));
		tick(12);
		chk("config_resistor_pin_src", 16'h1, 16'(dr.config_resistor_pin_src));
		chk("asg", 16'h0, 16'(dr.asg));
		tick(SET + 4);
		chk("asg", 16'h1, 16'(dr.asg));
		chk("config_resistor_pin_src", 16'h0, 16'(dr.config_resistor_pin_src));
		chk("adapter_good_output_oe", 16'h1, 16'(dr.adapter_good_output_oe));
		sense.asg_full = 1'b1;
		tick(8);
		chk("adapter_good_output_oe", 16'h0, 16'(dr.adapter_good_output_oe));
		chk("sw_en", 16'h1, 16'(dr.sw_en));
		chk("low_power", 16'h0, 16'(dr.low_power));
		chk("fsw", 16'(`CMS_FSW_733K), 16'(dr.fsw));
		chk("ilim", 16'(`CMS_ILIM_HI_MA / `CMS_LSB_MA), dr.ilim);
		chk("upper", 16'd8400, dr.upper);
		chk("lower", 16'd6000, dr.lower);
		chk("auto_thr", 16'd8000, dr.auto_thr);
		wr(8'h3c, 16'h0100);
		chk("fsw", 16'(`CMS_FSW_1M), 16'(dr.fsw));
		host.write_word(7'h2b, 8'h3c, 16'h0000);
		tick(8);
		chk("fsw", 16'(`CMS_FSW_1M), 16'(dr.fsw));
		chk("bfet", 16'h1, 16'(dr.bfet));
		// A short dip of the entry condition must restart the entry count.
		sense.vbat_below_auto = 1'b1;
		tick(A_DB - 8);
		sense.vbat_below_auto = 1'b0;
		tick(4);
		sense.vbat_below_auto = 1'b1;
		tick(A_DB - 4);
		chk("alert_oe", 16'h0, 16'(dr.alert_oe));
		tick(10);
		chk("alert_oe", 16'h1, 16'(dr.alert_oe));
		chk("timeout_susp", 16'h1, 16'(dr.timeout_susp));
		chk("chg", 16'(`CMS_AUTO_CHG_MA / `CMS_LSB_MA), dr.chg);
		sense.chg_low_cv = 1'b1;
		tick(EX_S - 4);
		chk("alert_oe", 16'h1, 16'(dr.alert_oe));
		tick(10);
		chk("alert_oe", 16'h0, 16'(dr.alert_oe));
		sense.chg_low_cv = 1'b0;
		sense.vbat_below_auto = 1'b0;
		tick(4);
		sense.vbat_below_auto = 1'b1;
		tick(A_DB + 8);
		chk("alert_oe", 16'h1, 16'(dr.alert_oe));
		sense.vbat_below_auto = 1'b0;
		tick(LIM - 60);
		chk("alert_oe", 16'h1, 16'(dr.alert_oe));
		tick(80);
		chk("alert_oe", 16'h0, 16'(dr.alert_oe));
		chk("chg", 16'h0, dr.chg);
		wr(8'h14, 16'h0064);
		chk("chg", 16'h0064, dr.chg);
		sense.vbat_below_auto = 1'b1;
		tick(A_DB + 10);
		chk("alert_oe", 16'h0, 16'(dr.alert_oe));
		wr(8'h4c, 16'h0080);
		tick(A_DB + 10);
		chk("alert_oe", 16'h1, 16'(dr.alert_oe));
		sense.vbat_below_auto = 1'b0;
		wr(8'h15, 16'h2000);
		chk("alert_oe", 16'h0, 16'(dr.alert_oe));
		chk("upper", 16'h2000, dr.upper);
		wr(8'h3c, 16'h1100);
		chk("bfet", 16'h1, 16'(dr.bfet));
		chk("asg", 16'h1, 16'(dr.asg));
		chk("sw_en", 16'h0, 16'(dr.sw_en));
		sense.bat_gone = 1'b1;
		tick(6);
		chk("sw_en", 16'h1, 16'(dr.sw_en));
		sense.bat_gone = 1'b0;
		wr(8'h3c, 16'h0100);
		wr(8'h3c, 16'h1100);
		chk("sw_en", 16'h0, 16'(dr.sw_en));
		wr(8'h3c, 16'h0100);
		chk("sw_en", 16'h1, 16'(dr.sw_en));
		wr(8'h3c, 16'h3100);
		chk("sw_en", 16'h0, 16'(dr.sw_en));
		sense.vbat_below_min = 1'b1;
		tick(6);
		chk("sw_en", 16'h1, 16'(dr.sw_en));
		sense.vbat_below_min = 1'b0;
		sense.zce_en = 1'b1;
		sense.ls_req = 1'b1;
		tick(1);
		sense.ls_req = 1'b0;
		tick(6);
		chk("ls_on", 16'h1, 16'(dr.ls_on));
		tick(10);
		chk("ls_on", 16'h0, 16'(dr.ls_on));
		sense.adp_det = 1'b0;
		sense.adapter_sense_input_ok = 1'b0;
		sense.asg_full = 1'b0;
		tick(8);
		chk("adapter_good_output_oe", 16'h1, 16'(dr.adapter_good_output_oe));
		chk("low_power", 16'h1, 16'(dr.low_power));
		wr(8'h3d, 16'h0800);
		sense.adp_det = 1'b1;
		sense.adapter_sense_input_ok = 1'b1;
		tick(DB_L - 4);
		chk("asg", 16'h0, 16'(dr.asg));
		tick(12);
		chk("asg", 16'h1, 16'(dr.asg));
		chk("config_resistor_pin_src", 16'h0, 16'(dr.config_resistor_pin_src));
		chk("ilim", 16'(`CMS_ILIM_HI_MA / `CMS_LSB_MA), dr.ilim);
		sense.adp_det = 1'b0;
		sense.adapter_sense_input_ok = 1'b0;
		tick(8);
		wr(8'h3c, 16'h0120);
		wr(8'h3d, 16'h0808);
		wr(8'h4c, 16'h0400);
		chk("ship", 16'h1, 16'(dr.ship));
		chk("mon_off", 16'h1, 16'(dr.mon_off));
		chk("cmp_off", 16'h1, 16'(dr.cmp_off));
		chk("bfet", 16'h0, 16'(dr.bfet));
		wr(8'h3c, 16'h0100);
		wr(8'h3d, 16'h0800);
		wr(8'h4c, 16'h0000);
		chk("ship", 16'h0, 16'(dr.ship));
		// Losing the bias supply drops the stored reading, so the next insertion reads a new code.
		sense.vdd_active = 1'b0;
		tick(6);
		chk("fsw", 16'(`CMS_FSW_733K), 16'(dr.fsw));
		config_resistor_pin_bin = 5'd14;
		sense.vdd_active = 1'b1;
		sense.adp_det = 1'b1;
		sense.adapter_sense_input_ok = 1'b1;
		tick(DB_S + 12);
		chk("config_resistor_pin_src", 16'h1, 16'(dr.config_resistor_pin_src));
		tick(SET + 8);
		chk("asg", 16'h1, 16'(dr.asg));
		chk("fsw", 16'(`CMS_FSW_1M), 16'(dr.fsw));
		chk("ilim", 16'(`CMS_ILIM_LO_MA / `CMS_LSB_MA), dr.ilim);
		chk("upper", 16'd16800, dr.upper);
		chk("lower", 16'd12000, dr.lower);
		print_verdict();
	end
endmodule
`default_nettype wire
